// ### crie_irq_enables.sv
// clock ready interrupt enables, stuck-clock flag and 40 kHz stable flag
//
// Functional notes
// - bit 14 enables aux2 loop lock interrupt
// - bit 13 enables aux1 loop lock interrupt
// - bit 12 enables main loop lock interrupt
// - bit 11 enables fast crystal stable interrupt
// - bit 10 enables 8 MHz oscillator interrupt
// - bit 9 enables slow crystal interrupt
// - bit 8 enables 40 kHz oscillator interrupt
// - hardware sets stuck flag on stalled crystal
// - stuck flag holds until clear written
// - writing one clears 40 kHz flag
`timescale 1ns/1ps
module crie_irq_enables #(
    parameter int unsigned NSRC = crie_pkg::NUM_SRC  // number of stable sources
) (
    input  wire logic            sys_clk_in,           // system bus clock
    input  wire logic            rst_in,               // synchronous reset, active high
    input  wire logic            clk_en_in,            // freezes all state while low
    input  wire logic            ctrl_wr_in,           // write strobe for enable word
    input  wire logic [16:0]     ctrl_wdata_in,        // written enables and clear bits
    input  wire logic [NSRC-1:0] stable_flags_in,      // stable flags from other logic
    input  wire logic            osc_40k_stable_in,    // 40 kHz stable event pulse
    input  wire logic            fast_crystal_stuck_in,// stuck detect, same domain
    output logic      [NSRC-1:0] irq_en_out,           // enable bits as stored
    output logic                 fast_crystal_stuck_flag_out, // sticky stuck flag
    output logic                 osc_40k_stable_flag_out,     // sticky 40 kHz flag
    output logic                 clk_irq_out           // combined interrupt request
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check: the fixed bit map serves exactly seven sources
    if (NSRC != crie_pkg::NUM_SRC) begin : g_bad_nsrc
        $error("crie_irq_enables: NSRC must equal the fixed source count");
    end

    ////////////////////////////////////////////////////////////////////////////
    // write decode helper
    // true when a write strobe carries a one at the given bit; both
    // write-one clears use it, so the two flags decode their clears alike
    function automatic logic wr_one_at(
        input logic        wr,   // write strobe
        input logic [16:0] word, // written word
        input int unsigned pos   // bit position to test
    );
        return wr && word[pos];
    endfunction : wr_one_at

    ////////////////////////////////////////////////////////////////////////////
    // enable register
    logic [NSRC-1:0] irq_en_r;    // software enables, index by source
    logic [NSRC-1:0] irq_en_nxt;  // next enable value
    logic            stuck_r;     // stuck-clock flag
    logic            osc40_r;     // 40 kHz stable flag
    logic [NSRC-1:0] flags_all;   // all stable flags with internal 40 kHz flag
    logic            stuck_clr;   // write-one clear of the stuck flag
    logic            osc40_clr;   // write-one clear of the 40 kHz flag

    // clear strobes; a clear only acts on a cycle with the clock enable high
    assign stuck_clr = wr_one_at(ctrl_wr_in, ctrl_wdata_in, crie_pkg::STUCK_FLAG_BIT);
    assign osc40_clr = wr_one_at(ctrl_wr_in, ctrl_wdata_in, crie_pkg::OSC_40K_CLR_BIT);

    // map written word bits onto source indices
    always_comb begin
        irq_en_nxt = irq_en_r;
        if (ctrl_wr_in) begin
            irq_en_nxt[crie_pkg::SRC_AUX2_LOOP] = ctrl_wdata_in[crie_pkg::AUX2_LOCK_IE_BIT];
            irq_en_nxt[crie_pkg::SRC_AUX1_LOOP] = ctrl_wdata_in[crie_pkg::AUX1_LOCK_IE_BIT];
            irq_en_nxt[crie_pkg::SRC_MAIN_LOOP] = ctrl_wdata_in[crie_pkg::MAIN_LOCK_IE_BIT];
            irq_en_nxt[crie_pkg::SRC_FAST_XTAL] = ctrl_wdata_in[crie_pkg::FAST_XTAL_IE_BIT];
            irq_en_nxt[crie_pkg::SRC_OSC_8M]    = ctrl_wdata_in[crie_pkg::OSC_8M_IE_BIT];
            irq_en_nxt[crie_pkg::SRC_SLOW_XTAL] = ctrl_wdata_in[crie_pkg::SLOW_XTAL_IE_BIT];
            irq_en_nxt[crie_pkg::SRC_OSC_40K]   = ctrl_wdata_in[crie_pkg::OSC_40K_IE_BIT];
        end
    end

    // store enables
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            irq_en_r <= crie_pkg::IE_RESET;
        end else if (clk_en_in) begin
            irq_en_r <= irq_en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stuck-clock flag: set wins over a simultaneous clear
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            stuck_r <= crie_pkg::FLAG_RESET;
        end else if (clk_en_in) begin
            // a stall seen in the same cycle as a clear keeps the flag up
            if (fast_crystal_stuck_in) begin
                stuck_r <= 1'b1;
            end else if (stuck_clr) begin
                // software acknowledged the stall
                stuck_r <= 1'b0;
            end
        end
    end

    // 40 kHz stable flag: set wins over a simultaneous clear
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            osc40_r <= crie_pkg::FLAG_RESET;
        end else if (clk_en_in) begin
            // a stable event in the same cycle as a clear keeps the flag up
            if (osc_40k_stable_in) begin
                osc40_r <= 1'b1;
            end else if (osc40_clr) begin
                // software acknowledged the stable event
                osc40_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt combine
    always_comb begin
        flags_all = stable_flags_in;
        flags_all[crie_pkg::SRC_OSC_40K] = osc40_r;
    end

    assign clk_irq_out = (|(flags_all & irq_en_r)) | stuck_r;
    assign irq_en_out  = irq_en_r;
    assign fast_crystal_stuck_flag_out = stuck_r;
    assign osc_40k_stable_flag_out     = osc40_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks on the stuck-clock flag
    // a stall seen with the clock enable high always lands in the flag
    a_stuck_sets: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && fast_crystal_stuck_in) |=> stuck_r)
        else $error("stuck flag not set");
    // nothing but a stall raises the flag
    a_stuck_spurious: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (!stuck_r && !(clk_en_in && fast_crystal_stuck_in)) |=> !stuck_r)
        else $error("stuck flag rose without a stall");
    // a clear with no competing stall empties the flag
    a_stuck_clears: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && stuck_clr && !fast_crystal_stuck_in) |=> !stuck_r)
        else $error("stuck flag not cleared");
    // without a clear the flag stays up
    a_stuck_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (stuck_r && !stuck_clr) |=> stuck_r)
        else $error("stuck flag dropped");

    ////////////////////////////////////////////////////////////////////////////
    // checks on the 40 kHz stable flag
    // a stable event with the clock enable high lands in the flag
    a_osc40_sets: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && osc_40k_stable_in) |=> osc40_r)
        else $error("40k flag not set");
    // a clear with no competing event empties the flag
    a_osc40_clears: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && osc40_clr && !osc_40k_stable_in) |=> !osc40_r)
        else $error("40k flag not cleared");
    // without a clear the flag stays up
    a_osc40_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (osc40_r && !osc40_clr) |=> osc40_r)
        else $error("40k flag dropped");

    ////////////////////////////////////////////////////////////////////////////
    // checks on the enable bits
    // clock enable low freezes every state bit
    a_frozen_state: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !clk_en_in |=> ($stable(irq_en_r) && $stable(stuck_r) && $stable(osc40_r)))
        else $error("state moved while frozen");
    // enables only change on an accepted write
    a_en_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !(clk_en_in && ctrl_wr_in) |=> $stable(irq_en_r))
        else $error("enables moved without a write");
    // each accepted write loads every enable from its own bit
    a_aux2_en: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && ctrl_wr_in)
        |=> irq_en_r[crie_pkg::SRC_AUX2_LOOP]
            == $past(ctrl_wdata_in[crie_pkg::AUX2_LOCK_IE_BIT]))
        else $error("aux2 enable wrong");
    a_aux1_en: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && ctrl_wr_in)
        |=> irq_en_r[crie_pkg::SRC_AUX1_LOOP]
            == $past(ctrl_wdata_in[crie_pkg::AUX1_LOCK_IE_BIT]))
        else $error("aux1 enable wrong");
    a_main_en: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && ctrl_wr_in)
        |=> irq_en_r[crie_pkg::SRC_MAIN_LOOP]
            == $past(ctrl_wdata_in[crie_pkg::MAIN_LOCK_IE_BIT]))
        else $error("main enable wrong");
    a_fast_en: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && ctrl_wr_in)
        |=> irq_en_r[crie_pkg::SRC_FAST_XTAL]
            == $past(ctrl_wdata_in[crie_pkg::FAST_XTAL_IE_BIT]))
        else $error("fast crystal enable wrong");
    a_osc8_en: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && ctrl_wr_in)
        |=> irq_en_r[crie_pkg::SRC_OSC_8M]
            == $past(ctrl_wdata_in[crie_pkg::OSC_8M_IE_BIT]))
        else $error("8m enable wrong");
    a_slow_en: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && ctrl_wr_in)
        |=> irq_en_r[crie_pkg::SRC_SLOW_XTAL]
            == $past(ctrl_wdata_in[crie_pkg::SLOW_XTAL_IE_BIT]))
        else $error("slow crystal enable wrong");
    a_osc40_en: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && ctrl_wr_in)
        |=> irq_en_r[crie_pkg::SRC_OSC_40K]
            == $past(ctrl_wdata_in[crie_pkg::OSC_40K_IE_BIT]))
        else $error("40k enable wrong");

    ////////////////////////////////////////////////////////////////////////////
    // checks on the combined request
    // a stuck crystal requests service whatever the enables say
    a_irq_stuck: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        stuck_r |-> clk_irq_out)
        else $error("stuck request missing");
    // an enabled main loop stable flag raises the request
    a_irq_main: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (irq_en_r[crie_pkg::SRC_MAIN_LOOP] && stable_flags_in[crie_pkg::SRC_MAIN_LOOP])
        |-> clk_irq_out)
        else $error("main loop request missing");
    // the 40 kHz source uses the internal sticky flag
    a_irq_osc40: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (irq_en_r[crie_pkg::SRC_OSC_40K] && osc40_r)
        |-> clk_irq_out)
        else $error("40k request missing");
    // everything masked and no stall: no request
    a_irq_masked: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (irq_en_r == 7'h00 && !stuck_r) |-> !clk_irq_out)
        else $error("request while all masked");

endmodule : crie_irq_enables

// ### crie_pkg.sv
// package holding bit positions and reset values for the clock ready interrupt block
package crie_pkg;
    // enable bit positions within the interrupt control word
    localparam int unsigned AUX2_LOCK_IE_BIT  = 14;
    localparam int unsigned AUX1_LOCK_IE_BIT  = 13;
    localparam int unsigned MAIN_LOCK_IE_BIT  = 12;
    localparam int unsigned FAST_XTAL_IE_BIT  = 11;
    localparam int unsigned OSC_8M_IE_BIT     = 10;
    localparam int unsigned SLOW_XTAL_IE_BIT  = 9;
    localparam int unsigned OSC_40K_IE_BIT    = 8;
    // stuck flag position and 40 kHz clear position
    localparam int unsigned STUCK_FLAG_BIT    = 7;
    localparam int unsigned OSC_40K_CLR_BIT   = 16;
    // number of stabilization sources
    localparam int unsigned NUM_SRC           = 7;
    // source index order on the stable-event vectors
    localparam int unsigned SRC_OSC_40K       = 0;
    localparam int unsigned SRC_SLOW_XTAL     = 1;
    localparam int unsigned SRC_OSC_8M        = 2;
    localparam int unsigned SRC_FAST_XTAL     = 3;
    localparam int unsigned SRC_MAIN_LOOP     = 4;
    localparam int unsigned SRC_AUX1_LOOP     = 5;
    localparam int unsigned SRC_AUX2_LOOP     = 6;
    // reset values
    localparam logic [6:0]  IE_RESET          = 7'h00;
    localparam logic        FLAG_RESET        = 1'b0;
endpackage : crie_pkg

// ### test_crie_irq_enables.sv
// self-checking testbench for the clock ready interrupt enable block
`timescale 1ns/1ps
module test_crie_irq_enables;
    logic        sys_clk_in            = 1'b0;   // 200 MHz system clock
    logic        rst_in                = 1'b1;   // synchronous reset
    logic        clk_en_in             = 1'b1;   // clock enable
    logic        ctrl_wr_in            = 1'b0;   // write strobe
    logic [16:0] ctrl_wdata_in         = 17'h00000; // write word
    logic [6:0]  stable_flags_in       = 7'h00;  // per-source stable flags
    logic        osc_40k_stable_in     = 1'b0;   // 40 kHz stable event
    logic        fast_crystal_stuck_in = 1'b0;   // stuck detect
    logic [6:0]  irq_en_out;                     // stored enables
    logic        stuck_flag;                     // sticky stuck flag
    logic        flag_40k;                       // sticky 40 kHz flag
    logic        clk_irq;                        // combined request
    int          num_errors            = 0;      // mismatches seen
    int          tests_run             = 0;      // comparisons made
    ////////////////////////////////////////////////////////////////////////////////
    // clock generator, 5 ns period
    initial forever #2.5 sys_clk_in = ~sys_clk_in;
    crie_irq_enables dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
        .ctrl_wr_in(ctrl_wr_in), .ctrl_wdata_in(ctrl_wdata_in),
        .stable_flags_in(stable_flags_in), .osc_40k_stable_in(osc_40k_stable_in),
        .fast_crystal_stuck_in(fast_crystal_stuck_in), .irq_en_out(irq_en_out),
        .fast_crystal_stuck_flag_out(stuck_flag), .osc_40k_stable_flag_out(flag_40k),
        .clk_irq_out(clk_irq));
    ////////////////////////////////////////////////////////////////////////////////
    // compare one value against its expectation
    task automatic check(input string name, input logic [6:0] seen, input logic [6:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // one-cycle write pulse after one idle edge, so back-to-back calls never
    // re-raise the strobe in the step that dropped it; ev[0] pulses the
    // 40 kHz event and ev[1] the stuck detect in the write cycle only
    task automatic wr(input logic [16:0] d, input logic [1:0] ev);
        @(negedge sys_clk_in);
        ctrl_wdata_in         = d;
        ctrl_wr_in            = 1'b1;
        osc_40k_stable_in     = ev[0];
        fast_crystal_stuck_in = ev[1];
        @(negedge sys_clk_in);
        ctrl_wr_in            = 1'b0;
        osc_40k_stable_in     = 1'b0;
        fast_crystal_stuck_in = 1'b0;
    endtask : wr
    // print counts and the verdict, then stop
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence, all inputs change on the falling edge
    initial begin
        repeat (20) @(negedge sys_clk_in);
        rst_in = 1'b0;
        check("reset enables", irq_en_out, 7'h00);
        check("reset flags", {5'h00, stuck_flag, flag_40k}, 7'h00);
        stable_flags_in = 7'h7f;  // all sources stable, index 0 ignored
        @(negedge sys_clk_in);
        check("masked irq", {6'h00, clk_irq}, 7'h00);
        // walk one enable bit across positions 8 to 14
        for (int i = 0; i < 7; i++) begin
            wr(17'h00100 << i, 2'b00);
            check("enable bit", irq_en_out, 7'h01 << i);
            check("gated irq", {6'h00, clk_irq}, {6'h00, i != 0});
        end
        // aux2 enabled but its stable flag low: no request
        stable_flags_in = 7'h3f;
        @(negedge sys_clk_in);
        check("aux2 flag low", {6'h00, clk_irq}, 7'h00);
        stable_flags_in = 7'h7f;
        $display("test enables done");
        // 40 kHz event with enable off, then on, then cleared
        wr(17'h00000, 2'b01);
        check("40k flag set", {6'h00, flag_40k}, 7'h01);
        check("40k masked", {6'h00, clk_irq}, 7'h00);
        wr(17'h00100, 2'b00);
        check("40k irq", {6'h00, clk_irq}, 7'h01);
        wr(17'h10100, 2'b00);
        check("40k clear", {6'h00, flag_40k}, 7'h00);
        check("40k irq gone", {6'h00, clk_irq}, 7'h00);
        // set and clear in the same cycle: set wins
        wr(17'h10000, 2'b01);
        check("40k set wins", {6'h00, flag_40k}, 7'h01);
        wr(17'h10000, 2'b00);
        check("40k clear again", {6'h00, flag_40k}, 7'h00);
        $display("test 40k flag done");
        // stuck crystal pulse, flag holds until the clear write
        wr(17'h00000, 2'b10);
        check("stuck set", {6'h00, stuck_flag}, 7'h01);
        check("stuck irq", {6'h00, clk_irq}, 7'h01);
        repeat (5) @(negedge sys_clk_in);
        check("stuck held", {6'h00, stuck_flag}, 7'h01);
        // stall and clear in the same cycle: the stall wins
        wr(17'h00080, 2'b10);
        check("stuck set wins", {6'h00, stuck_flag}, 7'h01);
        wr(17'h00080, 2'b00);
        check("stuck clear", {6'h00, stuck_flag}, 7'h00);
        check("irq idle", {6'h00, clk_irq}, 7'h00);
        $display("test stuck flag done");
        // clock enable low freezes writes and flag updates
        clk_en_in = 1'b0;
        wr(17'h07f00, 2'b11);
        clk_en_in = 1'b1;
        check("frozen enables", irq_en_out, 7'h00);
        check("frozen stuck", {6'h00, stuck_flag}, 7'h00);
        check("frozen 40k", {6'h00, flag_40k}, 7'h00);
        $display("test clock enable done");
        // second reset in mid-run with every enable and flag set
        wr(17'h07f00, 2'b11);
        check("all enables", irq_en_out, 7'h7f);
        check("all flags", {5'h00, stuck_flag, flag_40k}, 7'h03);
        rst_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        rst_in = 1'b0;
        check("reset enables again", irq_en_out, 7'h00);
        check("reset flags again", {5'h00, stuck_flag, flag_40k}, 7'h00);
        check("reset irq", {6'h00, clk_irq}, 7'h00);
        $display("test mid reset done");
        print_verdict();
    end
endmodule : test_crie_irq_enables
